//--- pkg/sport_cfg.svh
// Operation
// RULE_01 - Control bit 0 runs the port; when clear the pins serve as GPIO.
// RULE_02 - All bit timing derives from a 48 MHz base made from the clock.
// RULE_03 - Control bit 4 divides the selected baud rate by eight.
// RULE_04 - Codes 0-7 give 115.2/57.6/38.4/28.8/19.2/14.4/9.6/7.2 kbaud.
// RULE_05 - Prescaled codes give 14.4/7.2/4.8/3.6/2.4/1.8/1.2/0.9 kbaud.
// RULE_06 - The status register is read-only and writes to it change nothing.
// RULE_07 - Status bit 1 is high while an unread received byte is held.
// RULE_08 - With its enable set, a full receive buffer raises an interrupt.
// RULE_09 - Reading the data register clears the receive-full flag.
// RULE_10 - Status bit 0 sets on a data write, clears once shifted out.
// RULE_11 - With its enable set, an emptied transmit buffer interrupts.
// RULE_12 - Writing the data register starts sending that byte.
// RULE_13 - Data bits 7 to 0 carry the byte; the upper byte reads zero.
// RULE_14 - Software writes zero to every reserved bit.
// RULE_15 - Software sets the baud rate before relying on a non-default one.
// RULE_16 - One low start bit, eight data bits LSB first, one high stop bit.
`ifndef SPORT_CFG_SVH
`define SPORT_CFG_SVH

`define SPORT_IDX_CTRL     16'hc0e0
`define SPORT_IDX_STATUS   16'hc0e2
`define SPORT_IDX_DATA     16'hc0e4
`define SPORT_IDX_IRQ_STAT 16'hc100
`define SPORT_IDX_IRQ_MASK 16'hc102

`define SPORT_CTRL_EN      0
`define SPORT_CTRL_BAUD_LO 1
`define SPORT_CTRL_SCALE   4
`define SPORT_CTRL_RESET   5'h07
`define SPORT_ST_TX_FULL   0
`define SPORT_ST_RX_FULL   1

`define SPORT_SYS_HZ       200000000
`define SPORT_BASE_HZ      48000000
`define SPORT_PRESCALE     8
`define SPORT_ACC_W        8

`define SPORT_BAUD_0       115200
`define SPORT_BAUD_1       57600
`define SPORT_BAUD_2       38400
`define SPORT_BAUD_3       28800
`define SPORT_BAUD_4       19200
`define SPORT_BAUD_5       14400
`define SPORT_BAUD_6       9600
`define SPORT_BAUD_7       7200

`endif

//--- pkg/sport_pkg.sv
`default_nettype none
package sport_pkg;
  typedef enum logic [3:0] {
    SPORT_IDLE  = 4'h1,
    SPORT_START = 4'h2,
    SPORT_DATA  = 4'h4,
    SPORT_STOP  = 4'h8
  } sport_state_t;
endpackage
`default_nettype wire

//--- test/sport_peer.sv
`default_nettype none
module sport_peer (
  input  wire logic clk_sys,
  input  wire logic line_in,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned bit_cyc;
  int unsigned rx_count;
  logic [7:0]  got;
  logic [7:0]  shreg;
  logic        stop_ok;

  ////////////////////////////////////////////////////////////////////////////
  // sample frame
  initial begin
    line_out = 1'b1;
    bit_cyc  = 112;
    rx_count = 0;
    got      = 8'h00;
    stop_ok  = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (line_in === 1'b0) begin
        repeat (bit_cyc / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
          repeat (bit_cyc) @(posedge clk_sys);
          shreg[i] = line_in;
        end
        repeat (bit_cyc) @(posedge clk_sys);
        stop_ok = line_in;
        got     = shreg;
        rx_count++;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // send frame
  task automatic send(input logic [7:0] b, input logic good_stop);
    logic [9:0] fr;
    fr = {good_stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      line_out <= fr[i];
      repeat (bit_cyc - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    line_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
`include "sport_cfg.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SHIFT = 6;
  localparam int unsigned LIMIT = 80000;
  localparam int unsigned BAUD [8] = '{`SPORT_BAUD_0, `SPORT_BAUD_1,
    `SPORT_BAUD_2, `SPORT_BAUD_3, `SPORT_BAUD_4, `SPORT_BAUD_5,
    `SPORT_BAUD_6, `SPORT_BAUD_7};
  localparam logic [31:0] A_CTRL = {14'h0, `SPORT_IDX_CTRL, 2'h0};
  localparam logic [31:0] A_STAT = {14'h0, `SPORT_IDX_STATUS, 2'h0};
  localparam logic [31:0] A_DATA = {14'h0, `SPORT_IDX_DATA, 2'h0};
  localparam logic [31:0] A_IST  = {14'h0, `SPORT_IDX_IRQ_STAT, 2'h0};
  localparam logic [31:0] A_MSK  = {14'h0, `SPORT_IDX_IRQ_MASK, 2'h0};
  logic        clk_sys, reset, ce, psel, penable, pwrite, pready, pslverr;
  logic        irq, tx_out, tx_oe_n, rx_out, rx_oe_n;
  logic [31:0] paddr, pwdata, prdata;
  logic [1:0]  gpio_out, gpio_oe_n;
  wire logic   tx_line, rx_line, peer_drv;
  int          seed = 59;
  int unsigned err_count = 0;
  int unsigned checks = 0;
  int unsigned cyc = 0;

  assign tx_line = tx_oe_n ? 1'b1 : tx_out;
  assign rx_line = rx_oe_n ? peer_drv : rx_out;

  sport_uart #(.SIM_DIV_SHIFT(SHIFT)) uut (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .shared_tx_general_pin_in(tx_line),
    .shared_tx_general_pin_out(tx_out),
    .shared_tx_general_pin_oe_n(tx_oe_n),
    .shared_rx_general_pin_in(rx_line),
    .shared_rx_general_pin_out(rx_out),
    .shared_rx_general_pin_oe_n(rx_oe_n),
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));

  sport_peer peer (.clk_sys(clk_sys), .line_in(tx_line),
                   .line_out(peer_drv));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      results();
    end
  end

  function automatic int unsigned bit_of(input logic [2:0] c,
                                         input logic s);
    int unsigned d;
    d = (`SPORT_BASE_HZ + BAUD[c] / 2) / BAUD[c];
    if (s)
      d = d * `SPORT_PRESCALE;
    d = (d >> SHIFT) | 1;
    return (d * 200 + 24) / 48;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic results();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    logic        er, sc;
    logic [7:0]  b;
    int unsigned bc, n, t0;
    {reset, ce, psel, penable, pwrite} = 5'h18;
    {paddr, pwdata, gpio_out, gpio_oe_n} = {64'h0, 4'h3};
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, A_CTRL, 32'h0, rd, er);
    chk("ctrl_reset", rd, 32'h7);
    apb(1'b0, A_STAT, 32'h0, rd, er);
    chk("stat_reset", rd, 32'h0);
    chk("tx_oe_n_on", tx_oe_n, 1'b0);
    chk("rx_oe_n_on", rx_oe_n, 1'b1);
    apb(1'b0, 32'h0003_0000, 32'h0, rd, er);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_rd", rd, 32'h0);
    apb(1'b1, A_STAT, 32'h3, rd, er);
    apb(1'b0, A_STAT, 32'h0, rd, er);
    chk("stat_ro", rd, 32'h0);
    $display("test reset done");

    apb(1'b1, A_MSK, 32'h1, rd, er);
    for (int k = 0; k < 10; k++) begin
      sc = (k >= 8);
      bc = bit_of(k[2:0], sc);
      peer.bit_cyc = bc;
      apb(1'b1, A_CTRL, {27'h0, sc, k[2:0], 1'b1}, rd, er);
      b = 8'($random(seed));
      n = peer.rx_count;
      apb(1'b1, A_DATA, {24'h0, b}, rd, er);
      t0 = cyc;
      apb(1'b1, A_DATA, {24'h0, ~b}, rd, er);
      apb(1'b0, A_STAT, 32'h0, rd, er);
      chk("tx_full_set", rd, 32'h1);
      while (irq !== 1'b1 && cyc - t0 < 20 * bc) @(posedge clk_sys);
      chk("frame_len", (cyc - t0 + bc / 2 + 6 >= 10 * bc + 3) &&
          (cyc - t0 <= 10 * bc + bc / 2 + 9),
          1'b1);
      chk("tx_byte", peer.got, b);
      chk("tx_stop", peer.stop_ok, 1'b1);
      apb(1'b0, A_STAT, 32'h0, rd, er);
      chk("tx_full_clr", rd, 32'h0);
      apb(1'b0, A_IST, 32'h0, rd, er);
      chk("tx_event", rd, 32'h1);
      apb(1'b1, A_IST, 32'h1, rd, er);
      repeat (3 * bc) @(posedge clk_sys);
      chk("tx_frames", peer.rx_count, n + 1);
      chk("irq_clear", irq, 1'b0);
    end
    $display("test transmit done");

    bc = bit_of(3'h0, 1'b0);
    peer.bit_cyc = bc;
    apb(1'b1, A_CTRL, 32'h1, rd, er);
    for (int k = 0; k < 4; k++) begin
      b = (k == 0) ? 8'hff : 8'($random(seed));
      apb(1'b1, A_MSK, (k == 1) ? 32'h0 : 32'h2, rd, er);
      peer.send(b, k != 3);
      repeat (bc) @(posedge clk_sys);
      apb(1'b0, A_STAT, 32'h0, rd, er);
      chk("rx_full", rd[1], k != 3);
      chk("rx_irq", irq, k == 0 || k == 2);
      apb(1'b0, A_DATA, 32'h0, rd, er);
      if (k != 3)
        chk("rx_data", rd, {24'h0, b});
      apb(1'b0, A_STAT, 32'h0, rd, er);
      chk("rx_read_clr", rd[1], 1'b0);
      apb(1'b1, A_IST, 32'h2, rd, er);
    end
    $display("test receive done");

    apb(1'b1, A_CTRL, 32'h0, rd, er);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      gpio_out  <= 2'($random(seed));
      gpio_oe_n <= 2'($random(seed));
      repeat (3) @(posedge clk_sys);
      chk("gpio_pins", {tx_out, tx_oe_n, rx_out, rx_oe_n},
          {gpio_out[0], gpio_oe_n[0], gpio_out[1], gpio_oe_n[1]});
    end
    @(posedge clk_sys);
    ce        <= 1'b0;
    gpio_out  <= ~gpio_out;
    gpio_oe_n <= ~gpio_oe_n;
    repeat (3) @(posedge clk_sys);
    chk("ce_freeze", {tx_out, tx_oe_n, rx_out, rx_oe_n},
        {~gpio_out[0], ~gpio_oe_n[0], ~gpio_out[1], ~gpio_oe_n[1]});
    ce <= 1'b1;
    apb(1'b1, A_CTRL, 32'h7, rd, er);
    repeat (3) @(posedge clk_sys);
    chk("pins_back", {tx_oe_n, rx_oe_n}, 2'h1);
    $display("test general io done");
    results();
  end
endmodule
`default_nettype wire

//--- verilog/sport_uart.sv
// Design decision made here: the APB interface to the registers.
`include "sport_cfg.svh"
`default_nettype none
module sport_uart
  import sport_pkg::*;
#(
  parameter int unsigned SIM_DIV_SHIFT = 0
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        shared_tx_general_pin_in,
  output logic             shared_tx_general_pin_out,
  output logic             shared_tx_general_pin_oe_n,
  input  wire logic        shared_rx_general_pin_in,
  output logic             shared_rx_general_pin_out,
  output logic             shared_rx_general_pin_oe_n,
  input  wire logic [1:0]  gpio_out,
  input  wire logic [1:0]  gpio_oe_n
);

  function automatic logic [19:0] base_div(input logic [2:0] code);
    int unsigned b;
    b = `SPORT_BAUD_0;
    case (code)
      3'h0: b = `SPORT_BAUD_0;
      3'h1: b = `SPORT_BAUD_1;
      3'h2: b = `SPORT_BAUD_2;
      3'h3: b = `SPORT_BAUD_3;
      3'h4: b = `SPORT_BAUD_4;
      3'h5: b = `SPORT_BAUD_5;
      3'h6: b = `SPORT_BAUD_6;
      default: b = `SPORT_BAUD_7;
    endcase
    return 20'((`SPORT_BASE_HZ + b / 2) / b);
  endfunction
  function automatic logic [31:0] byte_addr(input logic [15:0] idx);
    return {14'h0000, idx, 2'h0};
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // Register bus decode
  logic [4:0]  ctrl;
  logic [1:0]  irq_stat, irq_mask;
  logic        tx_full, rx_full, rx_done, tx_done;
  logic [7:0]  tx_hold, rx_buf;
  wire setup    = psel & ~penable;
  wire done     = psel & penable & pready & ce;
  wire hit_ctrl = paddr == byte_addr(`SPORT_IDX_CTRL);
  wire hit_stat = paddr == byte_addr(`SPORT_IDX_STATUS);
  wire hit_data = paddr == byte_addr(`SPORT_IDX_DATA);
  wire hit_istat = paddr == byte_addr(`SPORT_IDX_IRQ_STAT);
  wire hit_imask = paddr == byte_addr(`SPORT_IDX_IRQ_MASK);
  wire hit_any  = hit_ctrl | hit_stat | hit_data | hit_istat | hit_imask;
  wire wr_ctrl  = done & pwrite & hit_ctrl;
  wire wr_data  = done & pwrite & hit_data;
  wire rd_data  = done & ~pwrite & hit_data;
  wire wr_istat = done & pwrite & hit_istat;
  wire wr_imask = done & pwrite & hit_imask;
  wire en       = ctrl[`SPORT_CTRL_EN];
  // RULE_06 status only read
  wire [31:0] rd_mux =
    hit_ctrl  ? {27'h0, ctrl} :
    hit_stat  ? {30'h0, rx_full, tx_full} :
    hit_data  ? {24'h0, rx_buf} :
    hit_istat ? {30'h0, irq_stat} :
    hit_imask ? {30'h0, irq_mask} : 32'h0;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      // RULE_13 byte in low bits
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control, flags, interrupts
  wire tx_take = wr_data & ~tx_full;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl     <= `SPORT_CTRL_RESET;
      irq_mask <= 2'h0;
      tx_hold  <= 8'h00;
    end else if (ce) begin
      if (wr_ctrl)
        ctrl <= pwdata[4:0];
      if (wr_imask)
        irq_mask <= pwdata[1:0];
      if (tx_take)
        tx_hold <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_full  <= 1'b0;
      rx_full  <= 1'b0;
      irq_stat <= 2'h0;
      irq      <= 1'b0;
    end else if (ce) begin
      // RULE_10 full on write, empty after shift
      if (tx_take)
        tx_full <= 1'b1;
      else if (tx_done)
        tx_full <= 1'b0;
      // RULE_09 read clears, arrival wins
      if (rx_done)
        rx_full <= 1'b1;
      else if (rd_data)
        rx_full <= 1'b0;
      // RULE_08 RULE_11 sticky events
      irq_stat <= (irq_stat & ~(wr_istat ? pwdata[1:0] : 2'h0))
                | {rx_done, tx_done};
      irq      <= |(irq_stat & irq_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // 48 MHz time base and bit period
  logic [`SPORT_ACC_W-1:0] acc;
  wire [`SPORT_ACC_W:0] acc_sum = {1'b0, acc} + (`SPORT_ACC_W+1)'(48);
  wire wrap   = acc_sum >= (`SPORT_ACC_W+1)'(200);
  wire tick48 = ce & wrap;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      acc <= '0;
    else if (ce)
      // RULE_02 fractional step to 48 MHz
      acc <= wrap ? `SPORT_ACC_W'(acc_sum - (`SPORT_ACC_W+1)'(200))
                  : acc_sum[`SPORT_ACC_W-1:0];
  end
  wire [19:0] div_base = base_div(ctrl[3:1]);
  // RULE_03 RULE_04 RULE_05 rate select
  wire [19:0] div_full = ctrl[`SPORT_CTRL_SCALE] ? {div_base[16:0], 3'h0}
                                                 : div_base;
  wire [19:0] div = (div_full >> SIM_DIV_SHIFT) | 20'h00001;
  wire [19:0] div_half = {1'b0, div[19:1]};

  //////////////////////////////////////////////////////////////////////////
  // Transmitter
  sport_state_t tx_state;
  logic [19:0]  tx_cnt;
  logic [7:0]   tx_shift;
  logic [2:0]   tx_bit;
  logic         tx_line;
  wire tx_tick = tick48 & (tx_cnt == div - 20'h1);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_state <= SPORT_IDLE;
      tx_cnt   <= 20'h0;
      tx_shift <= 8'h00;
      tx_bit   <= 3'h0;
      tx_line  <= 1'b1;
    end else if (ce) begin
      tx_cnt <= (tx_state == SPORT_IDLE || tx_tick) ? 20'h0
              : tx_cnt + (tick48 ? 20'h1 : 20'h0);
      if (!en) begin
        tx_state <= SPORT_IDLE;
        tx_line  <= 1'b1;
      end else begin
        case (tx_state)
          SPORT_IDLE: begin
            // RULE_12 write starts frame
            if (tx_full) begin
              tx_line  <= 1'b0;
              tx_shift <= tx_hold;
              tx_state <= SPORT_START;
            end
          end
          SPORT_START: begin
            if (tx_tick) begin
              tx_line  <= tx_shift[0];
              tx_bit   <= 3'h0;
              tx_state <= SPORT_DATA;
            end
          end
          SPORT_DATA: begin
            // RULE_16 LSB first then stop
            if (tx_tick) begin
              tx_bit   <= tx_bit + 3'h1;
              tx_shift <= {1'b0, tx_shift[7:1]};
              tx_line  <= (tx_bit == 3'h7) ? 1'b1 : tx_shift[1];
              if (tx_bit == 3'h7)
                tx_state <= SPORT_STOP;
            end
          end
          SPORT_STOP: begin
            if (tx_tick)
              tx_state <= SPORT_IDLE;
          end
          default: tx_state <= SPORT_IDLE;
        endcase
      end
    end
  end
  assign tx_done = en & (tx_state == SPORT_STOP) & tx_tick;
  //////////////////////////////////////////////////////////////////////////
  // Receiver
  sport_state_t rx_state;
  logic [19:0]  rx_cnt;
  logic [7:0]   rx_shift;
  logic [2:0]   rx_bit;
  wire rx_in   = shared_rx_general_pin_in;
  wire [19:0] rx_lim = (rx_state == SPORT_START) ? div_half : div;
  wire rx_tick = tick48 & (rx_cnt >= rx_lim - 20'h1);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_state <= SPORT_IDLE;
      rx_cnt   <= 20'h0;
      rx_shift <= 8'h00;
      rx_bit   <= 3'h0;
      rx_buf   <= 8'h00;
    end else if (ce) begin
      rx_cnt <= (rx_state == SPORT_IDLE || rx_tick) ? 20'h0
              : rx_cnt + (tick48 ? 20'h1 : 20'h0);
      if (rx_done)
        rx_buf <= rx_shift;
      if (!en)
        rx_state <= SPORT_IDLE;
      else begin
        case (rx_state)
          SPORT_IDLE: begin
            if (!rx_in)
              rx_state <= SPORT_START;
          end
          SPORT_START: begin
            // Mid start bit must still be low
            if (rx_tick) begin
              rx_bit   <= 3'h0;
              rx_state <= rx_in ? SPORT_IDLE : SPORT_DATA;
            end
          end
          SPORT_DATA: begin
            if (rx_tick) begin
              rx_shift <= {rx_in, rx_shift[7:1]};
              rx_bit   <= rx_bit + 3'h1;
              if (rx_bit == 3'h7)
                rx_state <= SPORT_STOP;
            end
          end
          SPORT_STOP: begin
            if (rx_tick)
              rx_state <= SPORT_IDLE;
          end
          default: rx_state <= SPORT_IDLE;
        endcase
      end
    end
  end
  // RULE_07 good stop bit fills buffer
  assign rx_done = en & (rx_state == SPORT_STOP) & rx_tick & rx_in;
  //////////////////////////////////////////////////////////////////////////
  // Pin sharing
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shared_tx_general_pin_out  <= 1'b1;
      shared_tx_general_pin_oe_n <= 1'b1;
      shared_rx_general_pin_out  <= 1'b0;
      shared_rx_general_pin_oe_n <= 1'b1;
    end else if (ce) begin
      // RULE_01 pins freed when off
      shared_tx_general_pin_out  <= en ? tx_line : gpio_out[0];
      shared_tx_general_pin_oe_n <= en ? 1'b0 : gpio_oe_n[0];
      shared_rx_general_pin_out  <= gpio_out[1];
      shared_rx_general_pin_oe_n <= en ? 1'b1 : gpio_oe_n[1];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_pin_free;
    ce && !en |=> shared_tx_general_pin_oe_n == $past(gpio_oe_n[0]);
  endproperty
  a_pin_free: assert property (p_pin_free) // RULE_01
    else $error("tx pin not released while disabled");
  property p_tick_rate;
    tick48 |=> !tick48 ##1 !tick48 ##1 !tick48;
  endproperty
  a_tick_rate: assert property (p_tick_rate) // RULE_02
    else $error("48 MHz base ticks too fast");
  property p_prescale;
    div_full == (ctrl[`SPORT_CTRL_SCALE] ? 20'(`SPORT_PRESCALE) : 20'h1)
                * base_div(ctrl[3:1]);
  endproperty
  a_prescale: assert property (p_prescale) // RULE_03
    else $error("prescaler does not divide by eight");
  property p_rx_full;
    ce && rx_done |=> rx_full && rx_buf == $past(rx_shift);
  endproperty
  a_rx_full: assert property (p_rx_full) // RULE_07
    else $error("received byte not flagged");
  property p_rd_clear;
    rd_data && !rx_done |=> !rx_full;
  endproperty
  a_rd_clear: assert property (p_rd_clear) // RULE_09
    else $error("data read did not clear receive full");
  property p_tx_set;
    tx_take |=> tx_full && tx_hold == $past(pwdata[7:0]);
  endproperty
  a_tx_set: assert property (p_tx_set) // RULE_10
    else $error("data write did not set transmit full");
  property p_tx_start;
    ce && en && tx_full && tx_state == SPORT_IDLE |=> !tx_line;
  endproperty
  a_tx_start: assert property (p_tx_start) // RULE_12
    else $error("transmission did not start");
  property p_irq;
    ce && |(irq_stat & irq_mask) |=> irq;
  endproperty
  a_irq: assert property (p_irq) // RULE_08
    else $error("unmasked event did not raise interrupt");
  property p_data_hi;
    pready && !pwrite && hit_data |-> prdata[31:8] == 24'h0;
  endproperty
  a_data_hi: assert property (p_data_hi) // RULE_13
    else $error("data register upper bits not zero");
  property p_idle_high;
    tx_state == SPORT_IDLE |-> tx_line;
  endproperty
  a_idle_high: assert property (p_idle_high) // RULE_16
    else $error("line not idle high");
endmodule
`default_nettype wire
